// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import vesr_pkg::*;
  localparam logic [7:0] KEY = 8'h5A;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [15:0] i_io_addr = 16'h0000;
  logic i_io_wr = 1'b0;
  logic i_io_rd = 1'b0;
  logic [7:0] i_io_wdata = 8'h00;
  logic [1:0] i_misc_clk_sel = 2'h0;
  logic i_std_mode13 = 1'b0;
  logic i_act_route_en = 1'b0;
  logic [1:0] i_act_route_sel = 2'h0;
  logic i_vga_access = 1'b0;
  logic i_activity_pin = 1'b0;
  logic [7:0] o_io_rdata;
  logic [1:0] o_vclk_sel;
  logic [6:0] o_vclk_numerator;
  logic o_io_rdata_valid, o_activity_pin, o_activity_pin_oe, o_unlocked;
  logic o_wbuf_en, o_snoop_en, o_linear_en, o_mmio_en, o_ge_access_en;
  logic o_ge_active, o_vafc_en, o_vafc_pclk_div2, o_enh16, o_enh256;
  logic o_dc15, o_dc16, o_dc24, o_text132, o_interlace, o_enh16_banked;
  logic o_tc_four_byte, o_vclk_set_b, o_vclk_osc_div4;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] midx = 8'h00;
  logic munl = 1'b0;
  logic [7:0] mreg [5] = '{8'h00, 8'h00, 8'h00, 8'h9C, 8'hA8};
  logic [31:0] lfsr = 32'h0001_7FFB;
  logic [7:0] tbl [8] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC7, 8'hC2,
    8'hC0};

  vesr_ctrl_regs #(.UNLOCK_KEY(KEY)) i_dut (.*);

  always #2 i_ref_clk = ~i_ref_clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [7:0] mread(input logic [15:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == VESR_PORT_INDEX) r = midx;
    else if (midx == VESR_IDX_PASSWORD) r = {7'h00, munl};
    else if (munl && midx inside {[8'hC0:8'hC4]}) r = mreg[midx - 8'hC0];
    // the status bit shows the pin, not what was written
    if (a == VESR_PORT_DATA && munl && midx == VESR_IDX_CLKPIN)
      r[5] = i_activity_pin;
    return r;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_io_addr = a;
    i_io_wdata = d;
    i_io_wr = 1'b1;
    @(negedge i_ref_clk);
    i_io_wr = 1'b0;
    if (a == VESR_PORT_INDEX) midx = d;
    else if (midx == VESR_IDX_PASSWORD) munl = d == KEY;
    else if (munl && midx inside {[8'hC0:8'hC4]})
      mreg[midx - 8'hC0] = midx == VESR_IDX_CLKPIN ? d & VESR_CLKPIN_WMASK : d;
  endtask

  task automatic io_rd(input logic [15:0] a);
    logic [7:0] e;
    logic hit;
    hit = a inside {VESR_PORT_INDEX, VESR_PORT_DATA};
    e = hit ? mread(a) : 8'h00;
    @(negedge i_ref_clk);
    i_io_addr = a;
    i_io_rd = 1'b1;
    @(negedge i_ref_clk);
    i_io_rd = 1'b0;
    check({7'h00, o_io_rdata_valid}, {7'h00, hit});
    check(o_io_rdata, e);
  endtask

  task automatic check_outs();
    logic [7:0] c1, c2, e1;
    logic [1:0] s;
    c1 = mreg[1];
    c2 = mreg[2];
    s = c2[4] ? c2[1:0] : i_misc_clk_sel;
    e1 = {c1[7:5], c1[4:2] & {3{c1[1]}}, c1[1] & !i_std_mode13, c1[0]};
    check({o_vafc_pclk_div2, o_vafc_en, o_ge_active, o_ge_access_en,
      o_mmio_en, o_linear_en, !o_snoop_en, o_wbuf_en}, mreg[0]);
    check({o_enh16_banked, o_interlace, o_text132, o_dc24, o_dc16, o_dc15,
      o_enh256, o_enh16}, e1);
    check({o_tc_four_byte, o_vclk_set_b, o_vclk_sel}, {c2[7], s[0], s});
    check({o_vclk_osc_div4, o_vclk_numerator}, mreg[3 + s[0]]);
    check({o_activity_pin_oe, o_activity_pin}, {i_act_route_en &&
      i_act_route_sel == 2'h3, c2[6] ? c2[5] : i_vga_access});
    check({7'h00, o_unlocked}, {7'h00, munl});
  endtask

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rstn = 1'b1;
    // locked bank refuses the write
    io_wr(VESR_PORT_INDEX, VESR_IDX_FEATURE);
    io_wr(VESR_PORT_DATA, 8'hFF);
    io_rd(VESR_PORT_DATA);
    check_outs();
    io_wr(VESR_PORT_INDEX, VESR_IDX_PASSWORD);
    io_wr(VESR_PORT_DATA, ~KEY);
    io_rd(VESR_PORT_DATA);
    io_wr(VESR_PORT_DATA, KEY);
    io_rd(VESR_PORT_DATA);
    for (int i = 0; i < 5; i++) begin
      io_wr(VESR_PORT_INDEX, 8'hC0 + 8'(i));
      io_rd(VESR_PORT_DATA);
    end
    $display("lock and reset test done");
    for (int i = 0; i < 48; i++) begin
      lfsr = lfsr_next(lfsr);
      io_wr(VESR_PORT_INDEX, tbl[lfsr[2:0]]);
      io_wr(VESR_PORT_DATA, lfsr[15:8]);
      {i_misc_clk_sel, i_std_mode13, i_act_route_en, i_act_route_sel,
        i_vga_access, i_activity_pin} = lfsr[26:19];
      repeat (6) @(negedge i_ref_clk);
      check_outs();
      io_rd(VESR_PORT_DATA);
      io_rd(VESR_PORT_INDEX);
    end
    $display("random register test done");
    io_wr(VESR_PORT_INDEX, VESR_IDX_PASSWORD);
    io_wr(VESR_PORT_DATA, 8'h00);
    io_wr(VESR_PORT_INDEX, VESR_IDX_MODE);
    io_wr(VESR_PORT_DATA, ~mreg[1]);
    io_rd(VESR_PORT_DATA);
    io_rd(16'h03C6);
    repeat (2) @(negedge i_ref_clk);
    check_outs();
    $display("relock test done");
    give_verdict();
  end
endmodule

// ==== bench/vesr_ctrl_regs_monitor.sv ====
`timescale 1ns/1ps
module vesr_chk
  import vesr_pkg::*;
(
  // clock, reset, host cycle and controller context
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_std_mode13,
  input wire logic i_act_route_en,
  input wire logic [1:0] i_act_route_sel,
  // watched outputs
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_rdata_valid,
  input wire logic o_enh256,
  input wire logic o_dc15,
  input wire logic o_vclk_set_b,
  input wire logic [1:0] o_vclk_sel,
  input wire logic o_activity_pin_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  logic hit;
  logic grant;
  assign hit = i_io_rd && i_io_addr inside {VESR_PORT_INDEX, VESR_PORT_DATA};
  assign grant = i_act_route_en && i_act_route_sel == VESR_ACT_ROUTE_MATCH;
  a_read_answer: assert property (hit |=> o_io_rdata_valid)
    else $error("read not answered");
  a_no_spurious: assert property (!hit |=> !o_io_rdata_valid)
    else $error("answer without read");
  a_rdata_idle: assert property (!o_io_rdata_valid |-> o_io_rdata == 8'h00)
    else $error("read data not idle");
  a_dc_needs256: assert property (o_dc15 && !$past(i_std_mode13) |-> o_enh256)
    else $error("direct colour without 256 mode");
  a_mode13_excl: assert property ($past(i_std_mode13) |-> !o_enh256)
    else $error("256 mode during mode 13");
  a_set_follow: assert property (o_vclk_set_b == o_vclk_sel[0])
    else $error("set select mismatch");
  a_pin_grant: assert property (grant |=> o_activity_pin_oe)
    else $error("pin not driven");
  a_pin_release: assert property (!grant |=> !o_activity_pin_oe)
    else $error("pin driven without grant");
  c_read: cover property (hit ##1 o_io_rdata_valid);
  c_enh256: cover property (o_dc15 && o_enh256);
  c_pin: cover property (grant ##1 o_activity_pin_oe);
endmodule

bind vesr_ctrl_regs vesr_chk i_chk (.i_ref_clk, .i_rstn, .i_io_addr,
  .i_io_rd, .i_std_mode13, .i_act_route_en, .i_act_route_sel, .o_io_rdata,
  .o_io_rdata_valid, .o_enh256, .o_dc15, .o_vclk_set_b, .o_vclk_sel,
  .o_activity_pin_oe);

// ==== include/vesr_pkg.sv ====
package vesr_pkg;

  // host i/o ports of the sequencer
  localparam logic [15:0] VESR_PORT_INDEX = 16'h03C4;
  localparam logic [15:0] VESR_PORT_DATA = 16'h03C5;

  // extended sequencer indices
  localparam logic [7:0] VESR_IDX_PASSWORD = 8'h05;
  localparam logic [7:0] VESR_IDX_FEATURE = 8'hC0;
  localparam logic [7:0] VESR_IDX_MODE = 8'hC1;
  localparam logic [7:0] VESR_IDX_CLKPIN = 8'hC2;
  localparam logic [7:0] VESR_IDX_NUM_A = 8'hC3;
  localparam logic [7:0] VESR_IDX_NUM_B = 8'hC4;

  // reset values
  localparam logic [7:0] VESR_RST_INDEX = 8'h00;
  localparam logic [7:0] VESR_RST_FEATURE = 8'h00;
  localparam logic [7:0] VESR_RST_MODE = 8'h00;
  localparam logic [7:0] VESR_RST_CLKPIN = 8'h00;
  localparam logic [7:0] VESR_RST_NUM_A = 8'h9C;
  localparam logic [7:0] VESR_RST_NUM_B = 8'hA8;
  localparam logic [7:0] VESR_READ_ZERO = 8'h00;

  // clock and pin select: writable bits, bits 3:2 reserved
  localparam logic [7:0] VESR_CLKPIN_WMASK = 8'hF3;

  // vga feature control fields
  localparam int VESR_FC_WBUF = 0;
  localparam int VESR_FC_SNOOP_OFF = 1;
  localparam int VESR_FC_LINEAR = 2;
  localparam int VESR_FC_MMIO = 3;
  localparam int VESR_FC_GE_ACCESS = 4;
  localparam int VESR_FC_GE_ACTIVE = 5;
  localparam int VESR_FC_VAFC = 6;
  localparam int VESR_FC_PCLK_DIV2 = 7;

  // extended mode select fields
  localparam int VESR_EM_ENH16 = 0;
  localparam int VESR_EM_ENH256 = 1;
  localparam int VESR_EM_DC15 = 2;
  localparam int VESR_EM_DC16 = 3;
  localparam int VESR_EM_DC24 = 4;
  localparam int VESR_EM_TEXT132 = 5;
  localparam int VESR_EM_INTERLACE = 6;
  localparam int VESR_EM_ENH16_BANK = 7;

  // clock and pin select fields
  localparam int VESR_CP_SEL_LO = 0;
  localparam int VESR_CP_SEL_HI = 1;
  localparam int VESR_CP_EXT_EN = 4;
  localparam int VESR_CP_PIN_DATA = 5;
  localparam int VESR_CP_PIN_USER = 6;
  localparam int VESR_CP_FOUR_BYTE = 7;

  // numerator fields
  localparam int VESR_NUM_HI = 6;
  localparam int VESR_NUM_DIV4 = 7;
  localparam int VESR_NUM_W = 7;

  // activity pin routing must read this to hand the pin over
  localparam logic [1:0] VESR_ACT_ROUTE_MATCH = 2'h3;

  // synthesizer reference and the usual divide-by-four threshold
  localparam int VESR_REF_OSC_KHZ = 14318;
  localparam int VESR_DIV4_BELOW_MHZ = 50;

endpackage

// ==== logic/vesr_clk_sel.sv ====
`timescale 1ns/1ps
module vesr_clk_sel
  import vesr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // select sources
  input wire logic [1:0] i_misc_sel,
  input wire logic [7:0] i_clkpin,
  input wire logic [7:0] i_num_a,
  input wire logic [7:0] i_num_b,
  // effective selection
  output logic [1:0] o_sel,
  output logic o_set_b,
  output logic [VESR_NUM_W-1:0] o_numerator,
  output logic o_osc_div4
);

  logic [1:0] next_sel;
  logic [7:0] next_num;

  always_comb begin
    next_sel = i_misc_sel;
    if (i_clkpin[VESR_CP_EXT_EN]) begin
      next_sel = i_clkpin[VESR_CP_SEL_HI:VESR_CP_SEL_LO];
    end
    next_num = next_sel[0] ? i_num_b : i_num_a;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sel <= 2'h0;
      o_set_b <= 1'b0;
      o_numerator <= VESR_RST_NUM_A[VESR_NUM_HI:0];
      o_osc_div4 <= VESR_RST_NUM_A[VESR_NUM_DIV4];
    end else begin
      o_sel <= next_sel;
      o_set_b <= next_sel[0];
      o_numerator <= next_num[VESR_NUM_HI:0];
      o_osc_div4 <= next_num[VESR_NUM_DIV4];
    end
  end

endmodule

// ==== logic/vesr_ctrl_regs.sv ====
`timescale 1ns/1ps
module vesr_ctrl_regs
  import vesr_pkg::*;
#(
  // password value that unlocks the bank; arbitrary
  parameter logic [7:0] UNLOCK_KEY = 8'h5A
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // host i/o cycle
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rdata_valid,
  // context from the rest of the controller
  input wire logic [1:0] i_misc_clk_sel,
  input wire logic i_std_mode13,
  input wire logic i_act_route_en,
  input wire logic [1:0] i_act_route_sel,
  input wire logic i_vga_access,
  // activity pin
  input wire logic i_activity_pin,
  output logic o_activity_pin,
  output logic o_activity_pin_oe,
  // global switches
  output logic o_unlocked,
  output logic o_wbuf_en,
  output logic o_snoop_en,
  output logic o_linear_en,
  output logic o_mmio_en,
  output logic o_ge_access_en,
  output logic o_ge_active,
  output logic o_vafc_en,
  output logic o_vafc_pclk_div2,
  // display modes
  output logic o_enh16,
  output logic o_enh256,
  output logic o_dc15,
  output logic o_dc16,
  output logic o_dc24,
  output logic o_text132,
  output logic o_interlace,
  output logic o_enh16_banked,
  output logic o_tc_four_byte,
  // video clock selection
  output logic [1:0] o_vclk_sel,
  output logic o_vclk_set_b,
  output logic [VESR_NUM_W-1:0] o_vclk_numerator,
  output logic o_vclk_osc_div4
);

  logic [7:0] index;
  logic unlocked;
  logic [7:0] feature;
  logic [7:0] mode;
  logic [7:0] clkpin;
  logic [7:0] num_a;
  logic [7:0] num_b;
  logic pin_level;
  logic wr_index;
  logic wr_data;
  logic rd_index;
  logic rd_data;
  logic ext_hit;
  logic [7:0] next_rdata;
  logic act_routed;
  logic wr_feature;
  logic wr_mode;
  logic wr_clkpin;
  logic wr_num_a;
  logic wr_num_b;
  logic [7:0] clkpin_view;

  assign wr_index = i_io_wr && (i_io_addr == VESR_PORT_INDEX);
  assign wr_data = i_io_wr && (i_io_addr == VESR_PORT_DATA);
  assign rd_index = i_io_rd && (i_io_addr == VESR_PORT_INDEX);
  assign rd_data = i_io_rd && (i_io_addr == VESR_PORT_DATA);
  // the whole extended bank sits behind the password
  assign ext_hit = unlocked && ((index == VESR_IDX_FEATURE) ||
      (index == VESR_IDX_MODE) || (index == VESR_IDX_CLKPIN) ||
      (index == VESR_IDX_NUM_A) || (index == VESR_IDX_NUM_B));
  assign act_routed = i_act_route_en &&
      (i_act_route_sel == VESR_ACT_ROUTE_MATCH);

  // one write strobe per register, each behind the password
  assign wr_feature = wr_data && ext_hit && (index == VESR_IDX_FEATURE);
  assign wr_mode = wr_data && ext_hit && (index == VESR_IDX_MODE);
  assign wr_clkpin = wr_data && ext_hit && (index == VESR_IDX_CLKPIN);
  assign wr_num_a = wr_data && ext_hit && (index == VESR_IDX_NUM_A);
  assign wr_num_b = wr_data && ext_hit && (index == VESR_IDX_NUM_B);

  // status bit shows the pin itself; reserved bits stay zero
  always_comb begin
    clkpin_view = clkpin & VESR_CLKPIN_WMASK;
    clkpin_view[VESR_CP_PIN_DATA] = pin_level;
  end

  vesr_sync3 u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_async(i_activity_pin),
    .o_level(pin_level)
  );

  vesr_clk_sel u_clk_sel (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_misc_sel(i_misc_clk_sel),
    .i_clkpin(clkpin),
    .i_num_a(num_a),
    .i_num_b(num_b),
    .o_sel(o_vclk_sel),
    .o_set_b(o_vclk_set_b),
    .o_numerator(o_vclk_numerator),
    .o_osc_div4(o_vclk_osc_div4)
  );

  // index latch
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      index <= VESR_RST_INDEX;
    end else if (wr_index) begin
      index <= i_io_wdata;
    end
  end

  // any write to the password index relocks unless it is the key
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      unlocked <= 1'b0;
    end else if (wr_data && (index == VESR_IDX_PASSWORD)) begin
      unlocked <= (i_io_wdata == UNLOCK_KEY);
    end
  end

  // vga feature control; everything it switches is off in reset, snooping too until bit 1, clear from reset, turns it on at the first clock after reset
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      feature <= VESR_RST_FEATURE;
    end else if (wr_feature) begin
      feature <= i_io_wdata;
    end
  end

  // extended mode select
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode <= VESR_RST_MODE;
    end else if (wr_mode) begin
      mode <= i_io_wdata;
    end
  end

  // clock and pin select; reserved bits never hold a one
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clkpin <= VESR_RST_CLKPIN;
    end else if (wr_clkpin) begin
      clkpin <= i_io_wdata & VESR_CLKPIN_WMASK;
    end
  end

  // numerator of video clock set a
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      num_a <= VESR_RST_NUM_A;
    end else if (wr_num_a) begin
      num_a <= i_io_wdata;
    end
  end

  // numerator of video clock set b
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      num_b <= VESR_RST_NUM_B;
    end else if (wr_num_b) begin
      num_b <= i_io_wdata;
    end
  end

  // read mux; locked or unmapped indices read zero
  always_comb begin
    next_rdata = VESR_READ_ZERO;
    if (rd_index) begin
      next_rdata = index;
    end else if (rd_data && (index == VESR_IDX_PASSWORD)) begin
      next_rdata = {7'h00, unlocked};
    end else if (rd_data && ext_hit) begin
      unique case (index)
        VESR_IDX_FEATURE: begin
          next_rdata = feature;
        end
        VESR_IDX_MODE: begin
          next_rdata = mode;
        end
        VESR_IDX_CLKPIN: begin
          next_rdata = clkpin_view;
        end
        VESR_IDX_NUM_A: begin
          next_rdata = num_a;
        end
        VESR_IDX_NUM_B: begin
          next_rdata = num_b;
        end
        default: begin
          next_rdata = VESR_READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_rdata <= VESR_READ_ZERO;
    end else begin
      o_io_rdata <= next_rdata;
    end
  end

  // one answer per taken read, whatever the index
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_rdata_valid <= 1'b0;
    end else begin
      o_io_rdata_valid <= rd_index || rd_data;
    end
  end

  // activity pin: released when routing is not handed to this block
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_activity_pin_oe <= 1'b0;
    end else begin
      o_activity_pin_oe <= act_routed;
    end
  end

  // user level or the access strobe drives the pin
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_activity_pin <= 1'b0;
    end else if (clkpin[VESR_CP_PIN_USER]) begin
      o_activity_pin <= clkpin[VESR_CP_PIN_DATA];
    end else begin
      o_activity_pin <= i_vga_access;
    end
  end

  // password state seen by the rest of the controller
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_unlocked <= 1'b0;
    end else begin
      o_unlocked <= unlocked;
    end
  end

  // switches follow the registers one cycle later
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wbuf_en <= 1'b0;
      o_snoop_en <= 1'b0;
      o_linear_en <= 1'b0;
      o_mmio_en <= 1'b0;
      o_ge_access_en <= 1'b0;
      o_ge_active <= 1'b0;
      o_vafc_en <= 1'b0;
      o_vafc_pclk_div2 <= 1'b0;
    end else begin
      o_wbuf_en <= feature[VESR_FC_WBUF];
      o_snoop_en <= !feature[VESR_FC_SNOOP_OFF];
      o_linear_en <= feature[VESR_FC_LINEAR];
      o_mmio_en <= feature[VESR_FC_MMIO];
      o_ge_access_en <= feature[VESR_FC_GE_ACCESS];
      o_ge_active <= feature[VESR_FC_GE_ACTIVE];
      o_vafc_en <= feature[VESR_FC_VAFC];
      o_vafc_pclk_div2 <= feature[VESR_FC_PCLK_DIV2];
    end
  end

  // colour depth decode; direct colour only rides on 256-colour
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_enh16 <= 1'b0;
      o_enh256 <= 1'b0;
      o_dc15 <= 1'b0;
      o_dc16 <= 1'b0;
      o_dc24 <= 1'b0;
    end else begin
      o_enh16 <= mode[VESR_EM_ENH16];
      o_enh256 <= mode[VESR_EM_ENH256] && !i_std_mode13;
      o_dc15 <= mode[VESR_EM_ENH256] && mode[VESR_EM_DC15];
      o_dc16 <= mode[VESR_EM_ENH256] && mode[VESR_EM_DC16];
      o_dc24 <= mode[VESR_EM_ENH256] && mode[VESR_EM_DC24];
    end
  end

  // text width, scan type and 16-colour memory layout
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_text132 <= 1'b0;
      o_interlace <= 1'b0;
      o_enh16_banked <= 1'b0;
    end else begin
      o_text132 <= mode[VESR_EM_TEXT132];
      o_interlace <= mode[VESR_EM_INTERLACE];
      o_enh16_banked <= mode[VESR_EM_ENH16_BANK];
    end
  end

  // true-colour layout lives in the clock and pin register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tc_four_byte <= 1'b0;
    end else begin
      o_tc_four_byte <= clkpin[VESR_CP_FOUR_BYTE];
    end
  end

endmodule

// ==== logic/vesr_sync3.sv ====
`timescale 1ns/1ps
module vesr_sync3
  import vesr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // asynchronous level in, filtered level out
  input wire logic i_async,
  output logic o_level
);

  logic ff1;
  logic ff2;
  logic ff3;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ff1 <= 1'b0;
      ff2 <= 1'b0;
      ff3 <= 1'b0;
    end else begin
      ff1 <= i_async;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // a change counts only once two settled stages agree
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_level <= 1'b0;
    end else if (ff2 == ff3) begin
      o_level <= ff3;
    end
  end

endmodule
